// [design/pcfs_defines.svh]
// Constants for the program counter and fetch sequencer
`ifndef PCFS_DEFINES_SVH
`define PCFS_DEFINES_SVH

// ****************************************
// Widths
// ****************************************
`define PCFS_PC_W        21
`define PCFS_HIGH_W      8
`define PCFS_UPPER_W     5
`define PCFS_INSTR_W     16
`define PCFS_ADDR_W      12
`define PCFS_PHASE_COUNT 4

// ****************************************
// Counter values
// ****************************************
`define PCFS_PC_RESET    21'h0_0000
`define PCFS_PC_STEP     21'h0_0002

// ****************************************
// Register offsets, byte addresses
// ****************************************
`define PCFS_OFF_LOW     12'h000
`define PCFS_OFF_HLATCH  12'h004
`define PCFS_OFF_ULATCH  12'h008
`define PCFS_OFF_CTRL    12'h00C
`define PCFS_OFF_STATUS  12'h010
`define PCFS_OFF_FADDR   12'h014
`define PCFS_OFF_INSTR   12'h018

// ****************************************
// Fields and reset values
// ****************************************
`define PCFS_CTRL_RUN_BIT   0
`define PCFS_CTRL_RESET     1'h1
`define PCFS_HLATCH_RESET   8'h00
`define PCFS_ULATCH_RESET   5'h00
`define PCFS_INSTR_RESET    16'h0000

`endif

// [design/pcfs_pkg.sv]
// Types shared by the program counter and fetch sequencer
package pcfs_pkg;

    typedef enum {
        pcfs_ph_one,
        pcfs_ph_two,
        pcfs_ph_three,
        pcfs_ph_four
    } pcfs_phase_t;

    typedef enum {
        pcfs_src_hold,
        pcfs_src_step,
        pcfs_src_jump,
        pcfs_src_soft
    } pcfs_pc_src_t;

endpackage

// [design/pcfs_phase_if.sv]
// Phase strobes carried from the phase generator to its users
`timescale 1ns/10ps
interface pcfs_phase_if;
    import pcfs_pkg::*;

    pcfs_phase_t phase;
    logic        phase_one;
    logic        phase_two;
    logic        phase_three;
    logic        phase_four;

    modport gen (output phase, phase_one, phase_two, phase_three, phase_four);
    modport use_ph (input phase, phase_one, phase_two, phase_three, phase_four);
endinterface

// [design/pcfs_phase_gen.sv]
// Four-phase instruction cycle generator
`timescale 1ns/10ps
module pcfs_phase_gen (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Sequencer run enable
    input  wire logic run,
    // Phase strobes
    pcfs_phase_if.gen ph
);
    import pcfs_pkg::*;

    pcfs_phase_t state;
    pcfs_phase_t next_state;

    always_comb
    begin
        case (state)
            pcfs_ph_one:   next_state = pcfs_ph_two;
            pcfs_ph_two:   next_state = pcfs_ph_three;
            pcfs_ph_three: next_state = pcfs_ph_four;
            pcfs_ph_four:  next_state = pcfs_ph_one;
            default:       next_state = pcfs_ph_one;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= pcfs_ph_one;
        else if (ce && run)
            state <= next_state;
    end

    // Strobes are gated by ce so each phase acts on exactly one edge
    assign ph.phase       = state;
    assign ph.phase_one   = ce && run && (state == pcfs_ph_one);
    assign ph.phase_two   = ce && run && (state == pcfs_ph_two);
    assign ph.phase_three = ce && run && (state == pcfs_ph_three);
    assign ph.phase_four  = ce && run && (state == pcfs_ph_four);
endmodule

// [design/pcfs_instr_stage.sv]
// Instruction register loaded at the fourth phase
`timescale 1ns/10ps
`include "pcfs_defines.svh"
module pcfs_instr_stage #(
    parameter int INSTR_W = `PCFS_INSTR_W
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // Phase strobes
    pcfs_phase_if.use_ph            ph,
    // Fetch side
    input  wire logic [INSTR_W-1:0] pmem_rdata,
    input  wire logic               flush,
    // Execute side
    output logic      [INSTR_W-1:0] exec_instr,
    output logic                    exec_valid
);
    import pcfs_pkg::*;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            exec_instr <= INSTR_W'(`PCFS_INSTR_RESET);
        else if (ph.phase_four)
            exec_instr <= pmem_rdata;
    end

    // valid through next cycle
    // A word fetched while a jump lands is stale and is marked invalid
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            exec_valid <= 1'b0;
        else if (ph.phase_four)
            exec_valid <= !flush;
    end
endmodule

// [design/pcfs_sequencer.sv]
// Program counter, latch registers and APB access for the fetch sequencer
`timescale 1ns/10ps
`include "pcfs_defines.svh"

module pcfs_sequencer #(
    parameter int PC_W    = `PCFS_PC_W,
    parameter int INSTR_W = `PCFS_INSTR_W
) (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    input  wire logic                         ce,
    // APB slave
    input  wire logic [`PCFS_ADDR_W-1:0]      paddr,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Program memory
    output logic      [PC_W-1:0]              pmem_addr,
    output logic                              pmem_rd,
    input  wire logic [INSTR_W-1:0]           pmem_rdata,
    // Execute unit
    input  wire logic                         jump_req,
    input  wire logic [PC_W-1:0]              jump_target,
    output logic      [INSTR_W-1:0]           exec_instr,
    output logic                              exec_valid,
    // Phase strobes
    output logic                              phase_one,
    output logic                              phase_two,
    output logic                              phase_three,
    output logic                              phase_four
);
    import pcfs_pkg::*;

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic pcfs_hit(
        input logic [`PCFS_ADDR_W-1:0] addr,
        input logic [`PCFS_ADDR_W-1:0] off
    );
        pcfs_hit = (addr == off);
    endfunction

    function automatic logic [PC_W-1:0] pcfs_align(
        input logic [PC_W-1:0] value
    );
        pcfs_align = {value[PC_W-1:1], 1'b0};
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic [`PCFS_UPPER_W-1:0] program_counter_upper_byte;
    logic [`PCFS_HIGH_W-1:0]  program_counter_high_byte;
    logic [`PCFS_HIGH_W-1:0]  program_counter_low_byte;
    logic [`PCFS_HIGH_W-1:0]  pc_high_latch;
    logic [`PCFS_UPPER_W-1:0] pc_upper_latch;
    logic                     run;
    logic [PC_W-1:0]          pc;
    logic [PC_W-1:0]          next_pc;
    pcfs_pc_src_t             pc_src;

    logic hit_low;
    logic hit_hlatch;
    logic hit_ulatch;
    logic hit_ctrl;
    logic hit_status;
    logic hit_faddr;
    logic hit_instr;
    logic hit_any;
    logic apb_setup;
    logic apb_done;
    logic wr_done;
    logic wr_lane0;
    logic low_write;
    logic low_read;
    logic jump_take;
    logic wr_hlatch;
    logic wr_ulatch;
    logic wr_ctrl;
    logic [31:0] rd_mux;

    pcfs_phase_if ph ();

    // ****************************************
    // Phase generation and instruction register
    // ****************************************
    pcfs_phase_gen u_phase_gen (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .run      (run),
        .ph       (ph)
    );

    pcfs_instr_stage #(
        .INSTR_W (INSTR_W)
    ) u_instr_stage (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .ph         (ph),
        .pmem_rdata (pmem_rdata),
        .flush      (jump_take),
        .exec_instr (exec_instr),
        .exec_valid (exec_valid)
    );

    assign phase_one   = ph.phase_one;
    assign phase_two   = ph.phase_two;
    assign phase_three = ph.phase_three;
    assign phase_four  = ph.phase_four;

    // ****************************************
    // APB decode
    // ****************************************
    assign hit_low    = pcfs_hit(paddr, `PCFS_OFF_LOW);
    assign hit_hlatch = pcfs_hit(paddr, `PCFS_OFF_HLATCH);
    assign hit_ulatch = pcfs_hit(paddr, `PCFS_OFF_ULATCH);
    assign hit_ctrl   = pcfs_hit(paddr, `PCFS_OFF_CTRL);
    assign hit_status = pcfs_hit(paddr, `PCFS_OFF_STATUS);
    assign hit_faddr  = pcfs_hit(paddr, `PCFS_OFF_FADDR);
    assign hit_instr  = pcfs_hit(paddr, `PCFS_OFF_INSTR);
    assign hit_any    = hit_low || hit_hlatch || hit_ulatch || hit_ctrl
                        || hit_status || hit_faddr || hit_instr;

    // Clock enable stalls the bus so no access slips past frozen state
    assign apb_setup = ce && psel && !penable;
    assign apb_done  = ce && psel && penable;
    assign wr_done   = apb_done && pwrite && hit_any;
    assign wr_lane0  = wr_done && pstrb[0];

    assign pready  = psel && penable && ce;
    assign pslverr = psel && penable && ce && !hit_any;

    // ****************************************
    // Counter control
    // ****************************************
    // ****************************************
    // Write strobes
    // ****************************************
    // One strobe per writable register keeps the register blocks simple
    assign wr_hlatch = wr_lane0 && hit_hlatch;
    assign wr_ulatch = wr_lane0 && hit_ulatch;
    assign wr_ctrl   = wr_lane0 && hit_ctrl;

    assign low_write = wr_lane0 && hit_low;
    // read sampled at setup
    // Sampled with the read data so the latches match the byte returned
    assign low_read  = apb_setup && !pwrite && hit_low;
    assign jump_take = jump_req && ph.phase_four;

    always_comb
    begin
        if (low_write)
        begin
            pc_src = pcfs_src_soft;
        end
        else if (jump_take)
        begin
            pc_src = pcfs_src_jump;
        end
        else if (ph.phase_one)
        begin
            pc_src = pcfs_src_step;
        end
        else
        begin
            pc_src = pcfs_src_hold;
        end
    end

    always_comb
    begin
        case (pc_src)
            pcfs_src_soft: next_pc = {pc_upper_latch, pc_high_latch, pwdata[7:0]};
            pcfs_src_jump: next_pc = jump_target;
            pcfs_src_step: next_pc = PC_W'(pc + `PCFS_PC_STEP);
            pcfs_src_hold: next_pc = pc;
            default:       next_pc = pc;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            pc <= PC_W'(`PCFS_PC_RESET);
        else
            pc <= pcfs_align(next_pc);
    end

    assign program_counter_upper_byte = pc[PC_W-1:16];
    assign program_counter_high_byte  = pc[15:8];
    assign program_counter_low_byte   = pc[7:0];

    // ****************************************
    // Fetch address
    // ****************************************
    // fetch address held
    // Captured before the step so the word fetched in phase four is
    // the one the counter named at the start of the cycle
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            pmem_addr <= PC_W'(`PCFS_PC_RESET);
        else if (ph.phase_one)
            pmem_addr <= pc;
    end

    assign pmem_rd = ph.phase_four;

    // ****************************************
    // Latch registers
    // ****************************************
    // eight-bit high latch
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_high_latch <= `PCFS_HLATCH_RESET;
        end
        else if (wr_hlatch)
        begin
            pc_high_latch <= pwdata[7:0];
        end
        else if (low_read)
        begin
            pc_high_latch <= program_counter_high_byte;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_upper_latch <= `PCFS_ULATCH_RESET;
        end
        else if (wr_ulatch)
        begin
            pc_upper_latch <= pwdata[`PCFS_UPPER_W-1:0];
        end
        else if (low_read)
        begin
            pc_upper_latch <= program_counter_upper_byte;
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    // Clearing run freezes the sequencer in its current phase, no fetch occurs
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run <= `PCFS_CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            run <= pwdata[`PCFS_CTRL_RUN_BIT];
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_low)
        begin
            rd_mux = {24'h00_0000, program_counter_low_byte};
        end
        else if (hit_hlatch)
        begin
            rd_mux = {24'h00_0000, pc_high_latch};
        end
        else if (hit_ulatch)
        begin
            rd_mux = {27'h000_0000, pc_upper_latch};
        end
        else if (hit_ctrl)
        begin
            rd_mux = {31'h0000_0000, run};
        end
        else if (hit_status)
        begin
            rd_mux = {28'h000_0000, phase_four, phase_three, exec_valid, run};
        end
        else if (hit_faddr)
        begin
            rd_mux = {11'h000, pmem_addr};
        end
        else if (hit_instr)
        begin
            rd_mux = {16'h0000, exec_instr};
        end
    end

    // Read data settles in the setup cycle, so reads need no wait state
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (apb_setup && !pwrite)
        begin
            prdata <= rd_mux;
        end
    end
endmodule

// [tb/pcfs_pmem_model.sv]
// Program memory model that answers fetches from the sequencer
`timescale 1ns/10ps
module pcfs_pmem_model (
    // Fetch port
    input  wire logic        core_clk,
    input  wire logic [20:0] pmem_addr,
    input  wire logic        pmem_rd,
    output logic      [15:0] pmem_rdata
);
    logic [15:0] last;
    // Word derived from address bits 16:1, so fetches that differ only above bit 16 return the same word
    // Outside the strobe the bus churns, so a late sample is caught
    assign pmem_rdata = pmem_rd ? (pmem_addr[16:1] ^ 16'hc3a5) : ~last;
    always_ff @(posedge core_clk)
        last <= pmem_rdata;
endmodule

// [tb/pcfs_seq_asserts.sv]
// Assertion checker bound to the fetch sequencer ports
`timescale 1ns/10ps
module pcfs_seq_asserts #(
    parameter int PC_W    = 21,
    parameter int INSTR_W = 16
) (
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               rst_n,
    input wire logic               ce,
    // APB
    input wire logic [11:0]        paddr,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [3:0]         pstrb,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // Fetch and execute
    input wire logic [PC_W-1:0]    pmem_addr,
    input wire logic [INSTR_W-1:0] pmem_rdata,
    input wire logic               jump_req,
    input wire logic [PC_W-1:0]    jump_target,
    input wire logic [INSTR_W-1:0] exec_instr,
    input wire logic               exec_valid,
    // Phases
    input wire logic               phase_one,
    input wire logic               phase_two,
    input wire logic               phase_four
);
    logic low_wr;
    logic jump_tk;
    logic disturbed;
    assign low_wr  = psel && penable && ce && pwrite && pstrb[0] && paddr == 12'h000;
    assign jump_tk = phase_four && ce && jump_req;
    // Step check is skipped once after anything that reloads the counter
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            disturbed <= 1'b1;
        else if (low_wr || jump_tk)
            disturbed <= 1'b1;
        else if (phase_one && ce)
            disturbed <= 1'b0;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_addr_even: assert property (pmem_addr[0] == 1'b0)
        else $error("fetch address odd");
    a_phase_next: assert property ((phase_one ##1 ce) |-> phase_two)
        else $error("phase two missing after phase one");
    a_phase_wrap: assert property ((phase_four ##1 ce) |-> phase_one)
        else $error("phase one missing after phase four");
    a_reset_clear: assert property ($rose(rst_n) |-> pmem_addr == 0 && !exec_valid)
        else $error("state not cleared by reset");
    a_seq_step: assert property ((phase_one && ce && !disturbed) |=>
        pmem_addr == $past(pmem_addr) + 2) else $error("fetch address did not step by two");
    a_addr_hold: assert property (!(phase_one && ce) |=> $stable(pmem_addr))
        else $error("fetch address moved outside phase one");
    a_jump_load: assert property ((jump_tk && !low_wr ##1 phase_one && ce && !low_wr) |=>
        pmem_addr == ($past(jump_target, 2) & ~1)) else $error("jump target not fetched");
    a_exec_load: assert property ((phase_four && ce) |=> exec_instr == $past(pmem_rdata)
        && exec_valid == !$past(jump_req)) else $error("instruction not latched");
    a_exec_hold: assert property (!(phase_four && ce) |=> $stable(exec_instr)
        && $stable(exec_valid)) else $error("instruction changed mid cycle");
    a_apb_ready: assert property (pready == (psel && penable && ce))
        else $error("ready does not follow access phase");
    a_err_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error response carries data");
    c_jump: cover property (jump_tk);
    c_low_wr: cover property (low_wr);
    c_err: cover property (pslverr);
endmodule

bind pcfs_sequencer pcfs_seq_asserts #(.PC_W(PC_W), .INSTR_W(INSTR_W)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .jump_req(jump_req), .jump_target(jump_target), .exec_instr(exec_instr),
    .exec_valid(exec_valid), .phase_one(phase_one), .phase_two(phase_two),
    .phase_four(phase_four));

// [tb/tb.sv]
// Self-checking testbench for the program counter and fetch sequencer
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module tb;
    logic        core_clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, err;
    logic        jump_req, pmem_rd, exec_valid, phase_one, phase_two, phase_three, phase_four;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, ph;
    logic [20:0] pmem_addr, jump_target, a0;
    logic [15:0] pmem_rdata, exec_instr;
    int          num_checks = 0, n_mismatch = 0, cycles = 0, c;
    assign ph = {phase_four, phase_three, phase_two, phase_one};

    pcfs_sequencer dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pmem_addr(pmem_addr),
        .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata), .jump_req(jump_req),
        .jump_target(jump_target), .exec_instr(exec_instr), .exec_valid(exec_valid),
        .phase_one(phase_one), .phase_two(phase_two), .phase_three(phase_three),
        .phase_four(phase_four));
    pcfs_pmem_model mem (.core_clk(core_clk), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
        .pmem_rdata(pmem_rdata));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ****************************************
    // Tasks
    // ****************************************
    function automatic logic [15:0] word(input logic [20:0] a);
        return a[16:1] ^ 16'hc3a5;
    endfunction

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One APB transfer; an idle edge first so no signal is driven twice at once
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge core_clk);
        end
        if (n == 20)
            n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Returns at the edge that ends a cycle of phase k
    task automatic wait_ph(input int k);
        int n;
        n = 0;
        @(posedge core_clk);
        while (ph[k] !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge core_clk);
        end
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        rst_n = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; pstrb = 4'hf; jump_req = 1'b0; jump_target = '0;
        repeat (5) @(posedge core_clk);
        #20 rst_n = 1'b1;
        `CHK(pmem_addr, 21'h00_0000)
        apb(0, 12'h004, 0); `CHK(rd, 32'h0000_0000)
        apb(0, 12'h00C, 0); `CHK(rd[0], 1'b1)
        apb(0, 12'h020, 0); `CHK(err, 1'b1)
        $display("test reset done");
        wait_ph(0); @(negedge core_clk); a0 = pmem_addr;
        wait_ph(3); @(negedge core_clk); `CHK(exec_instr, word(a0))
        `CHK(exec_valid, 1'b1)
        wait_ph(0); @(negedge core_clk); `CHK(pmem_addr, a0 + 21'h2)
        c = 0;
        wait_ph(0);
        do
        begin
            c++;
            @(posedge core_clk);
        end while (ph[0] !== 1'b1 && c < 20);
        `CHK(c, 4)
        $display("test fetch done");
        apb(1, 12'h004, 32'h0000_0012);
        apb(1, 12'h008, 32'h0000_00e3);
        apb(0, 12'h008, 0); `CHK(rd, 32'h0000_0003)
        apb(1, 12'h000, 32'h0000_0057);
        wait_ph(0); @(negedge core_clk); `CHK(pmem_addr, 21'h03_1256)
        pstrb <= 4'he;
        apb(1, 12'h004, 32'h0000_00ff);
        pstrb <= 4'hf;
        apb(0, 12'h004, 0); `CHK(rd, 32'h0000_0012)
        apb(1, 12'h004, 32'h0000_00aa);
        apb(1, 12'h008, 32'h0000_001c);
        apb(0, 12'h000, 0); `CHK(rd[0], 1'b0)
        apb(0, 12'h004, 0); `CHK(rd, 32'h0000_0012)
        apb(0, 12'h008, 0); `CHK(rd, 32'h0000_0003)
        wait_ph(0); @(negedge core_clk); `CHK(pmem_addr[20:8], 13'h0312)
        $display("test latch done");
        wait_ph(2);
        jump_target <= 21'h1a_bcd1;
        jump_req    <= 1'b1;
        @(posedge core_clk);
        jump_req    <= 1'b0;
        @(negedge core_clk); `CHK(exec_valid, 1'b0)
        wait_ph(0); @(negedge core_clk); `CHK(pmem_addr, 21'h1a_bcd0)
        wait_ph(3); @(negedge core_clk); `CHK(exec_instr, word(21'h1a_bcd0))
        apb(0, 12'h004, 0); `CHK(rd, 32'h0000_0012)
        $display("test jump done");
        @(posedge core_clk);
        ce <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK(ph, 4'h0)
        ce <= 1'b1;
        @(negedge core_clk);
        rst_n = 1'b0;
        #10 `CHK(pmem_addr, 21'h00_0000)
        @(negedge core_clk);
        rst_n = 1'b1;
        wait_ph(0); wait_ph(0); @(negedge core_clk); `CHK(pmem_addr, 21'h00_0002)
        apb(0, 12'h004, 0); `CHK(rd, 32'h0000_0000)
        $display("test restart done");
        complete_run();
    end
endmodule
